// ### logic/ccr_pkg.sv
package ccr_pkg;

    // register bus geometry
    localparam int ADDR_W = 4;
    localparam int DATA_W = 8;
    localparam int EVT_N = 2;

    // register offsets
    localparam logic [3:0] OFS_COMPARATOR_CONTROL = 4'h0;
    localparam logic [3:0] OFS_RESERVED_1 = 4'h1;
    localparam logic [3:0] OFS_INPUT_SELECT_CONTROL = 4'h2;
    localparam logic [3:0] OFS_RESERVED_3 = 4'h3;
    localparam logic [3:0] OFS_REFERENCE_LEVEL = 4'h4;
    localparam logic [3:0] OFS_RESERVED_5 = 4'h5;
    localparam logic [3:0] OFS_INTERRUPT_ENABLE = 4'h6;
    localparam logic [3:0] OFS_COMPARATOR_STATUS = 4'h7;
    localparam logic [3:0] OFS_EVENT_STATUS = 4'h8;
    localparam logic [3:0] OFS_EVENT_CLEAR = 4'h9;
    localparam logic [3:0] OFS_EVENT_ENABLE = 4'ha;

    // comparator_control fields
    localparam int BIT_RUN_IN_STANDBY = 7;
    localparam int BIT_OUTPUT_PAD_ENABLE = 6;
    localparam int POS_IRQ_EDGE_SELECT = 4;
    localparam int BIT_LOW_POWER_SELECT = 3;
    localparam int POS_HYSTERESIS_SELECT = 1;
    localparam int BIT_ENABLE = 0;

    // input_select_control fields
    localparam int BIT_INVERT = 7;
    localparam int POS_PLUS_INPUT_SELECT = 3;
    localparam int POS_MINUS_INPUT_SELECT = 0;

    // interrupt_enable and comparator_status fields
    localparam int BIT_COMPARE_IRQ = 0;
    localparam int BIT_STATE = 4;

    // own event register bits
    localparam int EVT_EDGE = 0;
    localparam int EVT_BAD_EDGE_MODE = 1;

    // reset values
    localparam logic [7:0] RST_COMPARATOR_CONTROL = 8'h00;
    localparam logic [7:0] RST_INPUT_SELECT_CONTROL = 8'h00;
    localparam logic [7:0] RST_REFERENCE_LEVEL = 8'hff;
    localparam logic [7:0] RST_INTERRUPT_ENABLE = 8'h00;

    // writable bit masks
    localparam logic [7:0] MASK_INPUT_SELECT_CONTROL = 8'h9b;
    localparam logic [7:0] MASK_INTERRUPT_ENABLE = 8'h01;

    // edge selection codes
    localparam logic [1:0] EDGE_ANY = 2'h0;
    localparam logic [1:0] EDGE_RESERVED = 2'h1;
    localparam logic [1:0] EDGE_FALL = 2'h2;
    localparam logic [1:0] EDGE_RISE = 2'h3;

    // register-bus request
    typedef struct packed {
        logic wr;
        logic rd;
        logic [3:0] addr;
        logic [7:0] wdata;
    } ccr_bus_req_t;

    // controls to the analog core
    typedef struct packed {
        logic enable;
        logic low_power_select;
        logic [1:0] hysteresis_select;
        logic [1:0] plus_input_select;
        logic [1:0] minus_input_select;
        logic [7:0] divider_reference;
    } ccr_analog_t;

endpackage

// ### logic/ccr_sync.sv
`timescale 1ns/10ps
// two-flop synchroniser for the comparator level
module ccr_sync (
    // clock and reset
    input wire logic i_clk_sys,
    input wire logic i_resetn,
    input wire logic i_ce,
    // level in and out
    input wire logic i_level,
    output logic o_level
);
    logic first_reg;
    logic first_next;
    logic second_reg;
    logic second_next;

    // next values, held while the clock enable is low
    always_comb begin
        first_next = i_ce ? i_level : first_reg;
        second_next = i_ce ? first_reg : second_reg;
    end

    // the first flop only feeds the second
    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            first_reg <= 1'b0;
            second_reg <= 1'b0;
        end else begin
            first_reg <= first_next;
            second_reg <= second_next;
        end
    end

    assign o_level = second_reg;
endmodule

// ### logic/ccr_edge_detect.sv
`timescale 1ns/10ps
// selected-edge detector on the synchronised comparator level
module ccr_edge_detect (
    // clock and reset
    input wire logic i_clk_sys,
    input wire logic i_resetn,
    input wire logic i_ce,
    // tracking enable, level and edge mode
    input wire logic i_track,
    input wire logic i_level,
    input wire logic [1:0] i_mode,
    // one-cycle hit
    output logic o_hit
);
    import ccr_pkg::*;

    logic prev_reg;
    logic prev_next;
    logic rise;
    logic fall;

    // edge decode by mode; reserved code raises nothing
    always_comb begin
        prev_next = (i_ce && i_track) ? i_level : prev_reg;
        rise = i_track && i_level && !prev_reg;
        fall = i_track && !i_level && prev_reg;
        unique case (i_mode)
            EDGE_ANY: o_hit = rise || fall;
            EDGE_FALL: o_hit = fall;
            EDGE_RISE: o_hit = rise;
            EDGE_RESERVED: o_hit = 1'b0;
        endcase
    end

    // previous level
    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            prev_reg <= 1'b0;
        end else begin
            prev_reg <= prev_next;
        end
    end
endmodule

// ### logic/ccr_top.sv
`timescale 1ns/10ps
// What this block does
// - run_in_standby keeps comparator alive in standby
// - standby freezes interrupt flag and status
// - output_pad_enable drives comparator output on pad
// - irq_edge_select picks both, falling, rising edges
// - low_power_select passed to analog core
// - hysteresis_select forwarded as none/small/medium/large
// - enable bit switches comparator on/off
// - invert flips result before all users
// - plus_input_select picks plus pin 0-3
// - minus_input_select picks minus pins or divider
// - reference level resets 0xff, drives divider
// - interrupt enable bit gates the flag's interrupt request; enabled event bits raise it regardless
// - state bit synchronised, three cycles late
// - writing one clears flag, zero keeps
// - selected edge sets interrupt flag
// - request high while flag and enable set
// - power-down disables comparator and pad
module ccr_top (
    // clock, reset, clock enable
    input wire logic i_clk_sys,
    input wire logic i_resetn,
    input wire logic i_ce,
    // register port
    input wire ccr_pkg::ccr_bus_req_t i_bus,
    output logic [ccr_pkg::DATA_W-1:0] o_rdata,
    // sleep state
    input wire logic i_sleep_standby,
    input wire logic i_sleep_powerdown,
    // analog core
    input wire logic i_cmp_raw,
    output ccr_pkg::ccr_analog_t o_analog,
    // pad and event
    output logic o_pad_out,
    output logic o_pad_oe,
    output logic o_event_level,
    // interrupt
    output logic o_irq
);
    import ccr_pkg::*;

    // true when a write strobe hits the given offset
    function automatic logic wr_hit(input ccr_bus_req_t req, input logic [3:0] ofs);
        wr_hit = req.wr && (req.addr == ofs);
    endfunction

    // register state
    logic [7:0] ctrl_reg;
    logic [7:0] ctrl_next;
    logic [7:0] mux_reg;
    logic [7:0] mux_next;
    logic [7:0] ref_reg;
    logic [7:0] ref_next;
    logic [7:0] ie_reg;
    logic [7:0] ie_next;
    logic flag_reg;
    logic flag_next;
    logic state_reg;
    logic state_next;
    logic [EVT_N-1:0] evt_reg;
    logic [EVT_N-1:0] evt_next;
    logic [EVT_N-1:0] evt_en_reg;
    logic [EVT_N-1:0] evt_en_next;
    logic [EVT_N-1:0] evt_set;
    logic [7:0] rdata_reg;
    logic [7:0] rdata_next;

    // output state
    ccr_analog_t analog_reg;
    ccr_analog_t analog_next;
    logic pad_out_reg;
    logic pad_out_next;
    logic pad_oe_reg;
    logic pad_oe_next;
    logic event_reg;
    logic event_next;
    logic irq_reg;
    logic irq_next;

    // derived
    logic active;
    logic update_ok;
    logic cmp_inv;
    logic cmp_sync;
    logic edge_hit;

    // comparator runs unless off, powered down or halted in standby
    always_comb begin
        active = ctrl_reg[BIT_ENABLE] && !i_sleep_powerdown
            && (!i_sleep_standby || ctrl_reg[BIT_RUN_IN_STANDBY]);
        update_ok = !i_sleep_standby;
        cmp_inv = i_cmp_raw ^ mux_reg[BIT_INVERT];
    end

    // synchronise the inverted result
    ccr_sync u_sync (
        .i_clk_sys(i_clk_sys),
        .i_resetn(i_resetn),
        .i_ce(i_ce),
        .i_level(cmp_inv),
        .o_level(cmp_sync)
    );

    // edge detection only while running and clocked
    ccr_edge_detect u_edge (
        .i_clk_sys(i_clk_sys),
        .i_resetn(i_resetn),
        .i_ce(i_ce),
        .i_track(active && update_ok),
        .i_level(cmp_sync),
        .i_mode(ctrl_reg[POS_IRQ_EDGE_SELECT +: 2]),
        .o_hit(edge_hit)
    );

    // control registers, reserved offsets decode to nothing
    always_comb begin
        ctrl_next = ctrl_reg;
        mux_next = mux_reg;
        ref_next = ref_reg;
        ie_next = ie_reg;
        evt_en_next = evt_en_reg;
        if (i_ce) begin
            if (wr_hit(i_bus, OFS_COMPARATOR_CONTROL)) begin
                ctrl_next = i_bus.wdata;
            end
            if (wr_hit(i_bus, OFS_INPUT_SELECT_CONTROL)) begin
                mux_next = i_bus.wdata & MASK_INPUT_SELECT_CONTROL;
            end
            if (wr_hit(i_bus, OFS_REFERENCE_LEVEL)) begin
                ref_next = i_bus.wdata;
            end
            if (wr_hit(i_bus, OFS_INTERRUPT_ENABLE)) begin
                ie_next = i_bus.wdata & MASK_INTERRUPT_ENABLE;
            end
            if (wr_hit(i_bus, OFS_EVENT_ENABLE)) begin
                evt_en_next = i_bus.wdata[EVT_N-1:0];
            end
        end
    end

    // control register flops
    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            ctrl_reg <= RST_COMPARATOR_CONTROL;
            mux_reg <= RST_INPUT_SELECT_CONTROL;
            ref_reg <= RST_REFERENCE_LEVEL;
            ie_reg <= RST_INTERRUPT_ENABLE;
            evt_en_reg <= '0;
        end else begin
            ctrl_reg <= ctrl_next;
            mux_reg <= mux_next;
            ref_reg <= ref_next;
            ie_reg <= ie_next;
            evt_en_reg <= evt_en_next;
        end
    end

    // interrupt flag and state bit; set wins over clear
    always_comb begin
        flag_next = flag_reg;
        state_next = state_reg;
        if (i_ce) begin
            if (wr_hit(i_bus, OFS_COMPARATOR_STATUS) && i_bus.wdata[BIT_COMPARE_IRQ]) begin
                flag_next = 1'b0;
            end
            if (edge_hit) begin
                flag_next = 1'b1;
            end
            if (update_ok) begin
                state_next = cmp_sync;
            end
        end
    end

    // own sticky event bits
    always_comb begin
        evt_set = '0;
        evt_set[EVT_EDGE] = edge_hit;
        evt_set[EVT_BAD_EDGE_MODE] = wr_hit(i_bus, OFS_COMPARATOR_CONTROL)
            && (i_bus.wdata[POS_IRQ_EDGE_SELECT +: 2] == EDGE_RESERVED);
    end

    // one sticky bit per event, write one to clear
    generate
        for (genvar g = 0; g < EVT_N; g++) begin : g_evt
            always_comb begin
                evt_next[g] = evt_reg[g];
                if (i_ce) begin
                    if (wr_hit(i_bus, OFS_EVENT_CLEAR) && i_bus.wdata[g]) begin
                        evt_next[g] = 1'b0;
                    end
                    if (evt_set[g]) begin
                        evt_next[g] = 1'b1;
                    end
                end
            end
        end
    endgenerate

    // status flops
    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            flag_reg <= 1'b0;
            state_reg <= 1'b0;
            evt_reg <= '0;
        end else begin
            flag_reg <= flag_next;
            state_reg <= state_next;
            evt_reg <= evt_next;
        end
    end

    // read mux, data valid one cycle after the strobe only
    always_comb begin
        rdata_next = 8'h00;
        if (i_ce && i_bus.rd) begin
            unique case (i_bus.addr)
                OFS_COMPARATOR_CONTROL: rdata_next = ctrl_reg;
                OFS_INPUT_SELECT_CONTROL: rdata_next = mux_reg;
                OFS_REFERENCE_LEVEL: rdata_next = ref_reg;
                OFS_INTERRUPT_ENABLE: rdata_next = ie_reg;
                OFS_COMPARATOR_STATUS: begin
                    rdata_next[BIT_STATE] = state_reg;
                    rdata_next[BIT_COMPARE_IRQ] = flag_reg;
                end
                OFS_EVENT_STATUS: rdata_next[EVT_N-1:0] = evt_reg;
                OFS_EVENT_ENABLE: rdata_next[EVT_N-1:0] = evt_en_reg;
                default: rdata_next = 8'h00;
            endcase
        end else if (!i_ce) begin
            rdata_next = rdata_reg;
        end
    end

    // outputs to analog core, pad, event and interrupt
    always_comb begin
        analog_next = analog_reg;
        pad_out_next = pad_out_reg;
        pad_oe_next = pad_oe_reg;
        event_next = event_reg;
        irq_next = irq_reg;
        if (i_ce) begin
            analog_next.enable = active;
            analog_next.low_power_select = ctrl_reg[BIT_LOW_POWER_SELECT];
            analog_next.hysteresis_select = ctrl_reg[POS_HYSTERESIS_SELECT +: 2];
            analog_next.plus_input_select = mux_reg[POS_PLUS_INPUT_SELECT +: 2];
            analog_next.minus_input_select = mux_reg[POS_MINUS_INPUT_SELECT +: 2];
            analog_next.divider_reference = ref_reg;
            pad_out_next = cmp_inv;
            pad_oe_next = ctrl_reg[BIT_OUTPUT_PAD_ENABLE] && active;
            event_next = cmp_inv && active;
            irq_next = (flag_reg && ie_reg[BIT_COMPARE_IRQ])
                || (|(evt_reg & evt_en_reg));
        end
    end

    // output flops
    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            analog_reg <= '0;
            pad_out_reg <= 1'b0;
            pad_oe_reg <= 1'b0;
            event_reg <= 1'b0;
            irq_reg <= 1'b0;
            rdata_reg <= 8'h00;
        end else begin
            analog_reg <= analog_next;
            pad_out_reg <= pad_out_next;
            pad_oe_reg <= pad_oe_next;
            event_reg <= event_next;
            irq_reg <= irq_next;
            rdata_reg <= rdata_next;
        end
    end

    assign o_analog = analog_reg;
    assign o_pad_out = pad_out_reg;
    assign o_pad_oe = pad_oe_reg;
    assign o_event_level = event_reg;
    assign o_irq = irq_reg;
    assign o_rdata = rdata_reg;

    // checks on the block's own behaviour
    default clocking cb @(posedge i_clk_sys);
    endclocking
    default disable iff (!i_resetn);

    standby_halt_a: assert property (
        (i_ce && i_sleep_standby && !ctrl_reg[BIT_RUN_IN_STANDBY]) |=> !o_analog.enable)
        else $error("comparator enabled in standby without run_in_standby");

    standby_freeze_a: assert property (
        (i_ce && i_sleep_standby && !i_bus.wr) |=> $stable(flag_reg) && $stable(state_reg))
        else $error("status changed while standby stopped the clock");

    pad_drive_a: assert property (
        i_ce |=> (o_pad_oe == ($past(ctrl_reg[BIT_OUTPUT_PAD_ENABLE]) && $past(active))))
        else $error("pad enable does not follow output_pad_enable");

    pad_invert_a: assert property (
        i_ce |=> o_pad_out == ($past(i_cmp_raw) ^ $past(mux_reg[BIT_INVERT])))
        else $error("pad level ignores invert bit");

    flag_set_a: assert property (
        (i_ce && edge_hit) |=> flag_reg)
        else $error("selected edge did not set interrupt flag");

    flag_clear_a: assert property (
        (i_ce && !edge_hit && wr_hit(i_bus, OFS_COMPARATOR_STATUS)
            && i_bus.wdata[BIT_COMPARE_IRQ]) |=> !flag_reg)
        else $error("writing one did not clear interrupt flag");

    flag_keep_a: assert property (
        (flag_reg && wr_hit(i_bus, OFS_COMPARATOR_STATUS) && !i_bus.wdata[BIT_COMPARE_IRQ])
            |=> flag_reg)
        else $error("writing zero cleared interrupt flag");

    irq_request_a: assert property (
        (i_ce && flag_reg && ie_reg[BIT_COMPARE_IRQ]) |=> o_irq)
        else $error("request low while flag and enable set");

    irq_gate_a: assert property (
        (i_ce && !(flag_reg && ie_reg[BIT_COMPARE_IRQ]) && !(|(evt_reg & evt_en_reg)))
            |=> !o_irq)
        else $error("request high without enabled source");

    state_delay_a: assert property (
        (i_ce && !i_sleep_standby) [*4] |-> state_reg == $past(cmp_inv, 3))
        else $error("state bit not three cycles behind output");

    powerdown_off_a: assert property (
        (i_ce && i_sleep_powerdown) |=> !o_analog.enable && !o_pad_oe)
        else $error("comparator or pad alive in power-down");

    reserved_read_a: assert property (
        (i_ce && i_bus.rd && (i_bus.addr == OFS_RESERVED_1 || i_bus.addr == OFS_RESERVED_3
            || i_bus.addr == OFS_RESERVED_5)) |=> o_rdata == 8'h00)
        else $error("reserved offset read not zero");

    analog_fwd_a: assert property (
        i_ce |=> o_analog.hysteresis_select == $past(ctrl_reg[POS_HYSTERESIS_SELECT +: 2])
            && o_analog.minus_input_select == $past(mux_reg[POS_MINUS_INPUT_SELECT +: 2]))
        else $error("analog controls not forwarded");
endmodule

// ### test/ccr_analog_model.sv
`timescale 1ns/10ps
// behavioural analog core: input selection, divider and comparator
module ccr_analog_model (
    // clock and reset
    input wire logic i_clk_sys,
    input wire logic i_resetn,
    // controls and pin voltages in millivolts
    input wire ccr_pkg::ccr_analog_t i_analog,
    input wire logic [11:0] i_plus_mv [4],
    input wire logic [11:0] i_minus_mv [3],
    // raw comparison result
    output logic o_cmp_raw
);
    import ccr_pkg::*;
    logic [11:0] plus_v;
    logic [11:0] minus_v;
    logic early_reg;
    // input multiplexers, divider is reference times four millivolts
    always_comb begin
        plus_v = i_plus_mv[i_analog.plus_input_select];
        if (i_analog.minus_input_select == 2'h3) begin
            minus_v = {2'h0, i_analog.divider_reference, 2'h0};
        end else begin
            minus_v = i_minus_mv[i_analog.minus_input_select];
        end
    end
    // switched-off core toggles, low power answers a cycle later
    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            early_reg <= 1'b0;
            o_cmp_raw <= 1'b0;
        end else begin
            early_reg <= (plus_v > minus_v);
            if (!i_analog.enable) begin
                o_cmp_raw <= ~o_cmp_raw;
            end else if (i_analog.low_power_select) begin
                o_cmp_raw <= early_reg;
            end else begin
                o_cmp_raw <= (plus_v > minus_v);
            end
        end
    end
endmodule

// ### test/comparator_control_regs_tb_top.sv
`timescale 1ns/10ps
// self-checking bench for the comparator control block
module comparator_control_regs_tb_top;
    import ccr_pkg::*;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic ce = 1'b1;
    logic stby = 1'b0;
    logic pdown = 1'b0;
    logic cmp_raw;
    ccr_bus_req_t bus = '0;
    logic [7:0] rdata;
    ccr_analog_t analog;
    logic pad_out;
    logic pad_oe;
    logic evt;
    logic irq;
    logic [11:0] plus_mv [4];
    logic [11:0] minus_mv [3];
    int err_total = 0;
    int samples_checked = 0;
    logic [7:0] d, c, m, r, ie, rsv;
    logic [3:0] ra;
    logic inv, f, lvl;
    logic [1:0] mode;

    // 250 MHz clock
    always #2 clk = ~clk;

    ccr_top dut_u (
        .i_clk_sys(clk), .i_resetn(resetn), .i_ce(ce), .i_bus(bus), .o_rdata(rdata),
        .i_sleep_standby(stby), .i_sleep_powerdown(pdown), .i_cmp_raw(cmp_raw),
        .o_analog(analog), .o_pad_out(pad_out), .o_pad_oe(pad_oe),
        .o_event_level(evt), .o_irq(irq)
    );
    ccr_analog_model model_u (
        .i_clk_sys(clk), .i_resetn(resetn), .i_analog(analog),
        .i_plus_mv(plus_mv), .i_minus_mv(minus_mv), .o_cmp_raw(cmp_raw)
    );

    // compare and count
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            err_total++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // one-cycle write strobe
    task automatic bus_wr(input logic [3:0] a, input logic [7:0] v);
        @(posedge clk);
        bus.wr <= 1'b1;
        bus.addr <= a;
        bus.wdata <= v;
        @(posedge clk);
        bus.wr <= 1'b0;
    endtask
    // one-cycle read strobe, data taken in the following cycle
    task automatic bus_rd(input logic [3:0] a, output logic [7:0] v);
        @(posedge clk);
        bus.rd <= 1'b1;
        bus.addr <= a;
        @(posedge clk);
        bus.rd <= 1'b0;
        #1;
        v = rdata;
    endtask
    // wait whole cycles, then step off the edge
    task automatic cycles(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // whether a level transition should set the flag
    function automatic logic exp_hit(input logic [1:0] md, input logic rising);
        case (md)
            EDGE_ANY: return 1'b1;
            EDGE_FALL: return !rising;
            EDGE_RISE: return rising;
            default: return 1'b0;
        endcase
    endfunction
    // controls expected at the analog core while awake
    function automatic ccr_analog_t exp_analog(input logic [7:0] cc, mm, rr);
        return '{cc[0], cc[3], cc[2:1], mm[4:3], mm[1:0], rr};
    endfunction
    // verdict and end of run
    task automatic finish_test();
        $display("checks %0d errors %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // hang guard, far beyond the expected run
    initial begin
        #100000;
        err_total++;
        finish_test();
    end

    // main sequence
    initial begin
        foreach (plus_mv[i]) plus_mv[i] = 12'h0;
        foreach (minus_mv[i]) minus_mv[i] = 12'h0;
        void'($urandom(58771));
        repeat (10) @(posedge clk);
        resetn <= 1'b1;
        // reset values, reserved offsets read zero
        for (int a = 0; a < 8; a++) begin
            bus_rd(4'(a), d);
            check(16'(d), (a == 4) ? 16'h00ff : 16'h0000);
        end
        check(analog, exp_analog(8'h00, 8'h00, 8'hff));
        // random register traffic with reserved writes among it
        repeat (40) begin
            c = 8'($urandom);
            m = 8'($urandom);
            r = 8'($urandom);
            ie = 8'($urandom);
            rsv = 8'($urandom);
            ra = 4'(2 * ($urandom % 3) + 1);
            foreach (plus_mv[i]) plus_mv[i] <= 12'($urandom % 1100);
            foreach (minus_mv[i]) minus_mv[i] <= 12'($urandom % 1100);
            bus_wr(OFS_COMPARATOR_CONTROL, c);
            bus_wr(OFS_INPUT_SELECT_CONTROL, m);
            bus_wr(OFS_REFERENCE_LEVEL, r);
            bus_wr(OFS_INTERRUPT_ENABLE, ie);
            bus_wr(ra, rsv);
            bus_rd(ra, d);
            check(16'(d), 16'h0);
            bus_rd(OFS_COMPARATOR_CONTROL, d);
            check(16'(d), 16'(c));
            bus_rd(OFS_INPUT_SELECT_CONTROL, d);
            check(16'(d), 16'(m & MASK_INPUT_SELECT_CONTROL));
            bus_rd(OFS_REFERENCE_LEVEL, d);
            check(16'(d), 16'(r));
            bus_rd(OFS_INTERRUPT_ENABLE, d);
            check(16'(d), 16'(ie & MASK_INTERRUPT_ENABLE));
            check(analog, exp_analog(c, m, r));
        end
        // every edge mode, with and without inversion, plus pin 0 against divider
        bus_wr(OFS_REFERENCE_LEVEL, 8'h80);
        for (int k = 0; k < 8; k++) begin
            inv = k[0];
            mode = 2'(k >> 1);
            bus_wr(OFS_INPUT_SELECT_CONTROL, {inv, 7'h03});
            bus_wr(OFS_INTERRUPT_ENABLE, {7'h0, inv});
            bus_wr(OFS_COMPARATOR_CONTROL, {2'b01, mode, 4'h1});
            plus_mv[0] <= 12'h0;
            cycles(8);
            bus_wr(OFS_COMPARATOR_STATUS, 8'h01);
            for (int s = 0; s < 2; s++) begin
                plus_mv[0] <= (s == 0) ? 12'd1000 : 12'd0;
                lvl = (s == 0) ^ inv;
                f = exp_hit(mode, lvl);
                cycles(8);
                bus_wr(OFS_COMPARATOR_STATUS, 8'h00);
                bus_rd(OFS_COMPARATOR_STATUS, d);
                check(16'(d), 16'({lvl, 3'h0, f}));
                check(16'({pad_out, pad_oe, evt}), 16'({lvl, 1'b1, lvl}));
                check(16'(irq), 16'(f & inv));
                bus_wr(OFS_COMPARATOR_STATUS, 8'h01);
                cycles(2);
                check(16'(irq), 16'h0);
            end
        end
        // standby halts unless told to run, and then freezes status
        bus_wr(OFS_COMPARATOR_CONTROL, 8'h41);
        stby <= 1'b1;
        cycles(3);
        check(16'({analog.enable, pad_oe}), 16'h0);
        bus_wr(OFS_COMPARATOR_CONTROL, 8'hc1);
        bus_rd(OFS_COMPARATOR_STATUS, c);
        plus_mv[0] <= 12'd1000;
        cycles(8);
        check(16'({analog.enable, pad_oe}), 16'h3);
        bus_rd(OFS_COMPARATOR_STATUS, d);
        check(16'(d), 16'(c));
        // power-down overrides run in standby
        @(posedge clk);
        pdown <= 1'b1;
        cycles(3);
        check(16'({analog.enable, pad_oe}), 16'h0);
        @(posedge clk);
        pdown <= 1'b0;
        stby <= 1'b0;
        // a strobe with the clock enable low is ignored
        ce <= 1'b0;
        bus_wr(OFS_REFERENCE_LEVEL, 8'h11);
        ce <= 1'b1;
        bus_rd(OFS_REFERENCE_LEVEL, d);
        check(16'(d), 16'h0080);
        // own event bits: reserved edge code is latched and can raise the request
        bus_wr(OFS_INTERRUPT_ENABLE, 8'h00);
        bus_wr(OFS_EVENT_CLEAR, 8'h03);
        bus_wr(OFS_COMPARATOR_CONTROL, {2'b00, EDGE_RESERVED, 4'h1});
        bus_wr(OFS_EVENT_ENABLE, 8'hff);
        bus_rd(OFS_EVENT_ENABLE, d);
        check(16'(d), 16'h0003);
        bus_rd(OFS_EVENT_STATUS, d);
        check(16'({d, irq}), 16'h0005);
        bus_wr(OFS_EVENT_CLEAR, 8'h02);
        cycles(2);
        bus_rd(OFS_EVENT_STATUS, d);
        check(16'({d, irq}), 16'h0000);
        finish_test();
    end
endmodule
